// *** hdl/usbli_status.sv ***
// usbli_status: status and control registers of the usb line interface:
// transceiver status mirror, serial line control, event flags, notify
// ports, frame counter, last pid and endpoint, endpoint marking.
// assumes a transceiver on asynchronous pins and a packet engine on clk.
`timescale 1ns/10ps
module usbli_status
    import usbli_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // register port, one 32-bit word per access
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]     reg_rdata,
    output logic            reg_rvalid,
    // transceiver receive pins
    input  wire logic [1:0] utmi_linestate,
    input  wire logic       utmi_rx_active,
    input  wire logic       utmi_rx_error,
    input  wire logic       utmi_rx_rcv,
    input  wire logic       utmi_rx_dm,
    input  wire logic       utmi_rx_dp,
    // transceiver on-the-go status pins
    input  wire logic       utmi_bvalid,
    input  wire logic       utmi_id_gnd,
    input  wire logic       utmi_host_disc,
    input  wire logic       utmi_vbus_valid,
    input  wire logic       utmi_sess_valid,
    input  wire logic       utmi_sess_end,
    // transceiver serial transmit controls
    output logic            transmit_enable_low,
    output logic            force_se0_transmit,
    output logic            serial_transmit_bit,
    output logic            full_low_speed_serial_select,
    // packet engine events
    input  wire logic       pkt_start,
    input  wire logic       tok_valid,
    input  wire logic       tok_crc5_ok,
    input  wire logic       tok_pid_ok,
    input  wire logic [6:0] tok_addr,
    input  wire logic [3:0] tok_endp,
    input  wire logic       pid_valid,
    input  wire logic [3:0] pid_value,
    input  wire logic       data_crc_fail,
    input  wire logic       sof_valid,
    input  wire logic [10:0] sof_frame,
    // packet engine results
    output logic            pkt_accept,
    output logic [4:0]      rx_endpoint,
    output logic            rx_endpoint_valid,
    output logic [6:0]      device_address,
    output logic            if_soft_reset,
    // notify ports and software-owned outputs
    output logic            notify_port_a,
    output logic            notify_port_b,
    output logic            notify_port_c,
    output logic            notify_port_d,
    output logic [31:0]     otg_flag_mask,
    output logic [7:0]      power_signal_value,
    output logic            power_signal_valid
);

    typedef struct packed {
        logic [NUM_PINS-1:0] sync1;
        logic [NUM_PINS-1:0] sync2;
        logic [6:0]          dev_addr;
        logic [3:0]          serial_ctl;
        logic [6:0]          sticky;
        logic [31:0]         port_masks;
        logic [10:0]         frame;
        logic [3:0]          pid;
        logic                ep_valid;
        logic [3:0]          ep;
        logic [15:0]         ep_mark;
        logic [31:0]         otg_mask;
        logic [8:0]          pwrsig;
        logic [4:0]          rx_ep;
        logic                rx_ep_valid;
        logic                pkt_accept;
        logic                soft_rst;
        logic [31:0]         rdata;
        logic                rvalid;
    } usbli_top_s;

    usbli_top_s           st;
    usbli_top_s           next_st;
    logic [NUM_PINS-1:0]  pin_raw;
    logic [5:0]           otg_now;
    logic [1:0]           ls_now;
    logic                 rcv_now;
    logic                 dm_now;
    logic                 dp_now;
    logic                 rxact_now;
    logic                 rxerr_now;
    logic                 tok_good;
    logic                 wr_sel;
    logic                 soft_now;
    logic [31:0]          rd_mux;
    logic [NUM_PORTS-1:0] notify;

    usbli_flag_if fl ();

    // gather asynchronous pins into one vector for the synchroniser
    assign pin_raw = {utmi_linestate, utmi_rx_active, utmi_rx_error, utmi_rx_rcv,
                      utmi_rx_dm, utmi_rx_dp, utmi_bvalid, utmi_id_gnd,
                      utmi_host_disc, utmi_vbus_valid, utmi_sess_valid, utmi_sess_end};

    // named views of the second synchroniser stage only
    assign otg_now   = st.sync2[PIN_OTG_LO +: 6];
    assign dp_now    = st.sync2[PIN_DP];
    assign dm_now    = st.sync2[PIN_DM];
    assign rcv_now   = st.sync2[PIN_RCV];
    assign rxerr_now = st.sync2[PIN_RXERR];
    assign rxact_now = st.sync2[PIN_RXACT];
    assign ls_now    = st.sync2[PIN_LS_LO +: 2];

    // token qualifies only with good checks and our own address
    assign tok_good = tok_valid & tok_crc5_ok & tok_pid_ok &
                      (tok_addr == st.dev_addr);

    // any write to the reset register restarts interface state
    assign soft_now = reg_wr & (reg_addr == OFS_IF_RESET);

    // drive the flag unit
    assign fl.cond[FLG_TOKEN] = tok_good;
    assign fl.cond[FLG_SE0]   = (ls_now == LS_SE0);
    assign fl.cond[FLG_K]     = (ls_now == LS_K);
    assign fl.cond[FLG_J]     = (ls_now == LS_J);
    assign fl.cond[FLG_CRC16] = data_crc_fail;
    assign fl.cond[FLG_RXACT] = rxact_now;
    assign fl.cond[FLG_RXERR] = rxerr_now;
    assign fl.sticky          = st.sticky;
    assign fl.pkt_start       = pkt_start;
    assign fl.soft_clr        = soft_now;
    assign wr_sel             = reg_wr & (reg_addr == OFS_EVENT_FLAGS);
    assign fl.clr_wr          = wr_sel ? reg_wdata[NUM_FLAGS-1:0] : '0;

    usbli_flag_unit u_flags (
        .clk   (clk),
        .rst_n (rst_n),
        .fl    (fl.unit)
    );

    // each notify port ors the flags its mask selects
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_notify
            assign notify[p] = |(fl.flags & st.port_masks[p*MASK_W +: NUM_FLAGS]);
        end
    endgenerate

    // read data selection; reserved bits read zero
    always_comb begin
        rd_mux = 32'h0;
        case (reg_addr)
            OFS_DEV_ADDR:    rd_mux[6:0]   = st.dev_addr;
            OFS_OTG_STATUS:  rd_mux[5:0]   = otg_now;
            OFS_SERIAL_CTL:  rd_mux[6:0]   = {rcv_now, dm_now, dp_now, st.serial_ctl};
            OFS_EVENT_FLAGS: rd_mux[6:0]   = fl.flags;
            OFS_FLAG_STICKY: rd_mux[6:0]   = st.sticky;
            OFS_PORT_MASKS:  rd_mux        = st.port_masks;
            OFS_FRAME_CNT:   rd_mux[10:0]  = st.frame;
            OFS_LAST_PID:    rd_mux[3:0]   = st.pid;
            OFS_LAST_EP:     rd_mux[4:0]   = {st.ep_valid, st.ep};
            OFS_EP_MARKING:  rd_mux[15:0]  = st.ep_mark;
            OFS_OTG_MASK:    rd_mux        = st.otg_mask;
            OFS_PWR_SIGNAL:  rd_mux[8:0]   = st.pwrsig;
            default:         rd_mux        = 32'h0;
        endcase
    end

    // next state: synchroniser, register writes, captures
    always_comb begin
        next_st            = st;
        next_st.sync1      = pin_raw;
        next_st.sync2      = st.sync1;
        next_st.rvalid     = reg_rd;
        next_st.rdata      = reg_rd ? rd_mux : st.rdata;
        next_st.soft_rst   = soft_now;
        next_st.pkt_accept = tok_good;
        // software writes; reserved bits are dropped
        if (reg_wr) begin
            case (reg_addr)
                OFS_DEV_ADDR:    next_st.dev_addr   = reg_wdata[6:0];
                OFS_SERIAL_CTL:  next_st.serial_ctl = reg_wdata[3:0];
                OFS_FLAG_STICKY: next_st.sticky     = reg_wdata[6:0];
                OFS_PORT_MASKS:  next_st.port_masks = reg_wdata;
                OFS_FRAME_CNT:   next_st.frame      = reg_wdata[10:0];
                OFS_EP_MARKING:  next_st.ep_mark    = reg_wdata[15:0];
                OFS_OTG_MASK:    next_st.otg_mask   = reg_wdata;
                OFS_PWR_SIGNAL:  next_st.pwrsig     = reg_wdata[8:0];
                default:         next_st.dev_addr   = st.dev_addr;
            endcase
        end
        // frame number from a received start-of-frame overrides a write
        if (sof_valid) begin
            next_st.frame = sof_frame;
        end
        // capture last pid of every received packet
        if (pid_valid) begin
            next_st.pid = pid_value;
        end
        // capture endpoint of an accepted token and mark it if selected
        next_st.rx_ep_valid = tok_good;
        if (tok_good) begin
            next_st.ep       = tok_endp;
            next_st.ep_valid = 1'b1;
            next_st.rx_ep    = st.ep_mark[tok_endp] ? ({1'b0, tok_endp} | EP_MARK_BIT)
                                                    : {1'b0, tok_endp};
        end
        // interface reset clears captured state, keeps configuration
        if (soft_now) begin
            next_st.frame       = '0;
            next_st.pid         = '0;
            next_st.ep          = '0;
            next_st.ep_valid    = 1'b0;
            next_st.rx_ep       = '0;
            next_st.rx_ep_valid = 1'b0;
            next_st.pkt_accept  = 1'b0;
        end
    end

    // state register; all fields take constants at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st            <= '0;
            st.serial_ctl <= SERIAL_RST;
        end else begin
            st <= next_st;
        end
    end

    // transceiver serial controls straight from the register
    assign transmit_enable_low          = st.serial_ctl[SER_TXENN];
    assign force_se0_transmit           = st.serial_ctl[SER_SE0];
    assign serial_transmit_bit          = st.serial_ctl[SER_TXDAT];
    assign full_low_speed_serial_select = st.serial_ctl[SER_FSLS];

    // remaining outputs
    assign reg_rdata          = st.rdata;
    assign reg_rvalid         = st.rvalid;
    assign pkt_accept         = st.pkt_accept;
    assign rx_endpoint        = st.rx_ep;
    assign rx_endpoint_valid  = st.rx_ep_valid;
    assign device_address     = st.dev_addr;
    assign if_soft_reset      = st.soft_rst;
    assign notify_port_a      = notify[0];
    assign notify_port_b      = notify[1];
    assign notify_port_c      = notify[2];
    assign notify_port_d      = notify[3];
    assign otg_flag_mask      = st.otg_mask;
    assign power_signal_value = st.pwrsig[7:0];
    assign power_signal_valid = st.pwrsig[8];

endmodule

// *** hdl/usbli_pkg.sv ***
// usbli_pkg: register map, field positions, reset values and line codes
// for the usb line interface status and flag unit.
// assumes 32-bit peripheral accesses addressed by byte offset.
package usbli_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_IF_RESET    = 8'h00;
    localparam logic [7:0] OFS_DEV_ADDR    = 8'h08;
    localparam logic [7:0] OFS_OTG_STATUS  = 8'h14;
    localparam logic [7:0] OFS_SERIAL_CTL  = 8'h18;
    localparam logic [7:0] OFS_EVENT_FLAGS = 8'h1c;
    localparam logic [7:0] OFS_FLAG_STICKY = 8'h20;
    localparam logic [7:0] OFS_PORT_MASKS  = 8'h24;
    localparam logic [7:0] OFS_FRAME_CNT   = 8'h28;
    localparam logic [7:0] OFS_LAST_PID    = 8'h2c;
    localparam logic [7:0] OFS_LAST_EP     = 8'h30;
    localparam logic [7:0] OFS_EP_MARKING  = 8'h34;
    localparam logic [7:0] OFS_OTG_MASK    = 8'h38;
    localparam logic [7:0] OFS_PWR_SIGNAL  = 8'h3c;

    // field widths
    localparam int NUM_FLAGS   = 7;
    localparam int NUM_PORTS   = 4;
    localparam int MASK_W      = 8;
    localparam int NUM_PINS    = 13;

    // serial line control bit positions
    localparam int SER_FSLS    = 0;
    localparam int SER_TXENN   = 1;
    localparam int SER_TXDAT   = 2;
    localparam int SER_SE0     = 3;
    localparam logic [3:0] SERIAL_RST = 4'h2;

    // event flag bit positions
    localparam int FLG_RXERR   = 0;
    localparam int FLG_RXACT   = 1;
    localparam int FLG_CRC16   = 2;
    localparam int FLG_J       = 3;
    localparam int FLG_K       = 4;
    localparam int FLG_SE0     = 5;
    localparam int FLG_TOKEN   = 6;
    // flags that follow a level when not held
    localparam logic [6:0] LEVEL_FLAGS = 7'h3b;

    // synchronised pin vector positions
    localparam int PIN_OTG_LO  = 0;
    localparam int PIN_DP      = 6;
    localparam int PIN_DM      = 7;
    localparam int PIN_RCV     = 8;
    localparam int PIN_RXERR   = 9;
    localparam int PIN_RXACT   = 10;
    localparam int PIN_LS_LO   = 11;

    // line state codes
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J   = 2'h1;
    localparam logic [1:0] LS_K   = 2'h2;

    // endpoint marking bit added on the receive port
    localparam logic [4:0] EP_MARK_BIT = 5'h10;

endpackage

// *** hdl/usbli_flag_if.sv ***
// usbli_flag_if: carrier between the register block and the flag unit.
// assumes both ends run on the same clock.
`timescale 1ns/10ps
interface usbli_flag_if;
    import usbli_pkg::*;
    logic [NUM_FLAGS-1:0] cond;      // event or level condition this cycle
    logic [NUM_FLAGS-1:0] sticky;    // hold selection per flag
    logic [NUM_FLAGS-1:0] clr_wr;    // software write-one-to-clear
    logic                 pkt_start; // next packet begins
    logic                 soft_clr;  // interface reset request
    logic [NUM_FLAGS-1:0] flags;     // current flag values

    modport unit (
        input  cond,
        input  sticky,
        input  clr_wr,
        input  pkt_start,
        input  soft_clr,
        output flags
    );
    modport ctrl (
        output cond,
        output sticky,
        output clr_wr,
        output pkt_start,
        output soft_clr,
        input  flags
    );
endinterface

// *** hdl/usbli_flag_unit.sv ***
// usbli_flag_unit: seven event flags with per-flag hold selection.
// assumes conditions arrive already synchronised to clk.
`timescale 1ns/10ps
module usbli_flag_unit
    import usbli_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // flag control and status
    usbli_flag_if.unit fl
);

    typedef struct packed {
        logic [NUM_FLAGS-1:0] flags;
    } usbli_flag_s;

    usbli_flag_s          st;
    usbli_flag_s          next_st;
    logic [NUM_FLAGS-1:0] next_bit;

    // per flag: a new event always wins over any clear
    genvar i;
    generate
        for (i = 0; i < NUM_FLAGS; i++) begin : g_flag
            logic hold;
            // held flags keep value until written one or soft reset; non-level others drop on packet start
            assign hold = ~fl.clr_wr[i] & ~fl.soft_clr &
                          (fl.sticky[i] | (~LEVEL_FLAGS[i] & ~fl.pkt_start));
            // level flags that are not held just follow their signal
            assign next_bit[i] = fl.cond[i] | (st.flags[i] & hold);
        end
    endgenerate

    // next state
    always_comb begin
        next_st       = st;
        next_st.flags = next_bit;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fl.flags = st.flags;

endmodule

// *** sim/usbli_status_chk.sv ***
// usbli_status_chk: concurrent checks on the register port, token results,
// soft reset and software-owned outputs; single clock, async active-low reset.
`timescale 1ns/10ps
module usbli_status_chk
    import usbli_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    // token inputs and results
    input wire logic        tok_valid,
    input wire logic        tok_crc5_ok,
    input wire logic        tok_pid_ok,
    input wire logic [6:0]  tok_addr,
    input wire logic [3:0]  tok_endp,
    input wire logic        pkt_accept,
    input wire logic [4:0]  rx_endpoint,
    input wire logic        rx_endpoint_valid,
    input wire logic [6:0]  device_address,
    input wire logic        if_soft_reset,
    // software-owned outputs
    input wire logic        transmit_enable_low,
    input wire logic        force_se0_transmit,
    input wire logic        serial_transmit_bit,
    input wire logic        full_low_speed_serial_select,
    input wire logic [7:0]  power_signal_value,
    input wire logic        power_signal_valid
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // serial control bits reach the transceiver one edge after the write
    property p_serial_drive;
        reg_wr && reg_addr == OFS_SERIAL_CTL |=> {force_se0_transmit, serial_transmit_bit,
            transmit_enable_low, full_low_speed_serial_select} == $past(reg_wdata[3:0]);
    endproperty
    a_serial_drive: assert property (p_serial_drive)
        else $error("serial controls do not follow write");
    // a qualified token is accepted with its endpoint one edge later
    property p_accept;
        tok_valid && tok_crc5_ok && tok_pid_ok && tok_addr == device_address
            |=> pkt_accept && rx_endpoint_valid && rx_endpoint[3:0] == $past(tok_endp);
    endproperty
    a_accept: assert property (p_accept)
        else $error("qualified token not accepted");
    // anything short of a full qualification is never accepted
    property p_reject;
        !(tok_valid && tok_crc5_ok && tok_pid_ok && tok_addr == device_address) |=> !pkt_accept;
    endproperty
    a_reject: assert property (p_reject)
        else $error("unqualified token accepted");
    // endpoint only moves on acceptance or soft reset
    property p_ep_hold;
        !pkt_accept && !if_soft_reset |-> $stable(rx_endpoint);
    endproperty
    a_ep_hold: assert property (p_ep_hold)
        else $error("endpoint changed without token");
    // soft reset pulse tracks writes to offset zero exactly
    property p_soft_reset;
        if_soft_reset == $past(reg_wr && reg_addr == OFS_IF_RESET);
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset pulse mismatch");
    // read data valid one cycle after each read strobe, data held otherwise
    property p_read_valid;
        reg_rvalid == $past(reg_rd);
    endproperty
    a_read_valid: assert property (p_read_valid)
        else $error("read valid mismatch");
    property p_read_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read data changed without read");
    // unmapped offset reads zero
    property p_unmapped;
        reg_rd && reg_addr == 8'h44 |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    // power signalling outputs follow their write
    property p_power;
        reg_wr && reg_addr == OFS_PWR_SIGNAL
            |=> {power_signal_valid, power_signal_value} == $past(reg_wdata[8:0]);
    endproperty
    a_power: assert property (p_power)
        else $error("power signalling mismatch");
endmodule

// *** sim/usbli_xcvr_model.sv ***
// usbli_xcvr_model: behavioural transceiver driving receive and otg pins.
// assumes the bench sets requested levels; pins settle a few ns later.
`timescale 1ns/10ps
module usbli_xcvr_model
    import usbli_pkg::*;
(
    // requested levels: rx_req is {active, error, rcv, dm, dp}
    input  wire logic [1:0] line_req,
    input  wire logic [4:0] rx_req,
    input  wire logic [5:0] otg_req,
    // transceiver pins
    output logic [1:0]      utmi_linestate,
    output logic            utmi_rx_active,
    output logic            utmi_rx_error,
    output logic            utmi_rx_rcv,
    output logic            utmi_rx_dm,
    output logic            utmi_rx_dp,
    output logic            utmi_bvalid,
    output logic            utmi_id_gnd,
    output logic            utmi_host_disc,
    output logic            utmi_vbus_valid,
    output logic            utmi_sess_valid,
    output logic            utmi_sess_end
);
    // pins lag the request so they never move on a clock edge
    assign #3 utmi_linestate = line_req;
    assign #3 {utmi_rx_active, utmi_rx_error, utmi_rx_rcv, utmi_rx_dm, utmi_rx_dp} = rx_req;
    assign #3 {utmi_bvalid, utmi_id_gnd, utmi_host_disc, utmi_vbus_valid, utmi_sess_valid,
               utmi_sess_end} = otg_req;
endmodule

// *** sim/testbench.sv ***
// testbench: register sweep, pin mirrors, flags, notify ports, tokens and
// soft reset of usbli_status; inputs change on the falling edge of clk.
`timescale 1ns/10ps
module testbench import usbli_pkg::*;;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] rst;
        logic [31:0] wdata;
        logic [31:0] exp;
    } usbli_row_s;
    logic clk, rst_n, reg_wr, reg_rd, tok_valid, tok_crc5_ok, tok_pid_ok, reg_rvalid;
    logic pkt_accept, rx_endpoint_valid, if_soft_reset, transmit_enable_low;
    logic force_se0_transmit, serial_transmit_bit, full_low_speed_serial_select;
    logic notify_port_a, notify_port_b, notify_port_c, notify_port_d, power_signal_valid;
    logic utmi_rx_active, utmi_rx_error, utmi_rx_rcv, utmi_rx_dm, utmi_rx_dp, utmi_bvalid;
    logic utmi_id_gnd, utmi_host_disc, utmi_vbus_valid, utmi_sess_valid, utmi_sess_end;
    logic [7:0] reg_addr, power_signal_value;
    logic [31:0] reg_wdata, reg_rdata, otg_flag_mask;
    logic [6:0] tok_addr, device_address;
    logic [3:0] tok_endp, pid_value, ev;
    logic [10:0] sof_frame;
    logic [4:0] rx_endpoint, rx_req;
    logic [1:0] utmi_linestate, line_req;
    logic [5:0] otg_req;
    int err_count, samples_checked;
    wire pkt_start = ev[3], data_crc_fail = ev[2], pid_valid = ev[1], sof_valid = ev[0];
    usbli_row_s rows [12] = '{'{8'h08, 0, 32'hffffffff, 32'h7f}, '{8'h14, 0, 32'hff, 0},
        '{8'h18, 32'h2, 32'hffffffff, 32'hf}, '{8'h20, 0, 32'hffffffff, 32'h7f},
        '{8'h24, 0, 32'h80402001, 32'h80402001}, '{8'h28, 0, 32'hffffffff, 32'h7ff},
        '{8'h2c, 0, 32'hf, 0}, '{8'h30, 0, 32'h1f, 0}, '{8'h34, 0, 32'hffffffff, 32'hffff},
        '{8'h38, 0, 32'ha5a5a5a5, 32'ha5a5a5a5}, '{8'h3c, 0, 32'hffffffff, 32'h1ff},
        '{8'h44, 0, 32'hffffffff, 0}};

    usbli_xcvr_model xcvr (.line_req, .rx_req, .otg_req, .utmi_linestate, .utmi_rx_active,
        .utmi_rx_error, .utmi_rx_rcv, .utmi_rx_dm, .utmi_rx_dp, .utmi_bvalid, .utmi_id_gnd,
        .utmi_host_disc, .utmi_vbus_valid, .utmi_sess_valid, .utmi_sess_end);
    usbli_status dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .utmi_linestate, .utmi_rx_active, .utmi_rx_error, .utmi_rx_rcv,
        .utmi_rx_dm, .utmi_rx_dp, .utmi_bvalid, .utmi_id_gnd, .utmi_host_disc,
        .utmi_vbus_valid, .utmi_sess_valid, .utmi_sess_end, .transmit_enable_low,
        .force_se0_transmit, .serial_transmit_bit, .full_low_speed_serial_select,
        .pkt_start, .tok_valid, .tok_crc5_ok, .tok_pid_ok, .tok_addr, .tok_endp, .pid_valid,
        .pid_value, .data_crc_fail, .sof_valid, .sof_frame, .pkt_accept, .rx_endpoint,
        .rx_endpoint_valid, .device_address, .if_soft_reset, .notify_port_a, .notify_port_b,
        .notify_port_c, .notify_port_d, .otg_flag_mask, .power_signal_value,
        .power_signal_valid);

    // compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_rd = 1'b0;
        check("read valid", {31'h0, reg_rvalid}, 32'h1);
        check($sformatf("reg %h", a), reg_rdata, exp);
    endtask
    task automatic pulse(input logic [3:0] v);
        @(negedge clk);
        ev = v;
        @(negedge clk);
        ev = 4'h0;
    endtask
    // exp is {accept, endpoint as delivered}
    task automatic token(input logic [6:0] a, input logic [3:0] e, input logic [5:0] exp);
        @(negedge clk);
        {tok_valid, tok_addr, tok_endp} = {1'b1, a, e};
        @(negedge clk);
        tok_valid = 1'b0;
        check("token result", {26'h0, pkt_accept, rx_endpoint}, {26'h0, exp});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, tok_valid, tok_addr, tok_endp} = '0;
        {tok_crc5_ok, tok_pid_ok, pid_value, sof_frame, ev, rx_req, otg_req} = '0;
        line_req = LS_J;
        repeat (4) @(negedge clk);
        check("tx at reset", {28'h0, force_se0_transmit, serial_transmit_bit,
            transmit_enable_low, full_low_speed_serial_select}, 32'h2);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].addr, rows[i].rst);
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rows[i].exp);
        end
        check("otg mask out", otg_flag_mask, 32'ha5a5a5a5);
        check("power out", {23'h0, power_signal_valid, power_signal_value}, 32'h1ff);
        // pin mirrors, then enable serial transmission
        otg_req = 6'h2a;
        rx_req = 5'h05;
        repeat (4) @(negedge clk);
        rd(OFS_OTG_STATUS, 32'h2a);
        rd(OFS_SERIAL_CTL, 32'h5f);
        wr(OFS_SERIAL_CTL, 32'h5);
        check("tx enabled", {28'h0, force_se0_transmit, serial_transmit_bit,
            transmit_enable_low, full_low_speed_serial_select}, 32'h5);
        // level flags follow their signals while not held
        wr(OFS_FLAG_STICKY, 32'h0);
        wr(OFS_EVENT_FLAGS, 32'h7f);
        line_req = LS_K;
        rx_req = 5'h10;
        repeat (4) @(negedge clk);
        rd(OFS_EVENT_FLAGS, 32'h12);
        line_req = LS_J;
        rx_req = 5'h08;
        repeat (4) @(negedge clk);
        rd(OFS_EVENT_FLAGS, 32'h09);
        // held flags stay until written with one
        wr(OFS_FLAG_STICKY, 32'h7f);
        line_req = LS_SE0;
        rx_req = 5'h0;
        repeat (4) @(negedge clk);
        rd(OFS_EVENT_FLAGS, 32'h29);
        wr(OFS_EVENT_FLAGS, 32'h01);
        rd(OFS_EVENT_FLAGS, 32'h28);
        // notify ports: a on j, b on error, c on se0, d on crc16 or token
        wr(OFS_PORT_MASKS, 32'h44200108);
        check("notify", {notify_port_a, notify_port_b, notify_port_c, notify_port_d}, 4'ha);
        wr(OFS_EVENT_FLAGS, 32'h7f);
        check("notify", {notify_port_a, notify_port_b, notify_port_c, notify_port_d}, 4'h2);
        // tokens: marked, unmarked and three kinds of rejection
        wr(OFS_FLAG_STICKY, 32'h0);
        line_req = LS_J;
        wr(OFS_DEV_ADDR, 32'h5);
        wr(OFS_EP_MARKING, 32'h8);
        {tok_crc5_ok, tok_pid_ok} = 2'b11;
        token(7'h05, 4'h3, 6'h33);
        rd(OFS_LAST_EP, 32'h13);
        token(7'h05, 4'h2, 6'h22);
        token(7'h06, 4'h4, 6'h02);
        tok_pid_ok = 1'b0;
        token(7'h05, 4'h4, 6'h02);
        {tok_crc5_ok, tok_pid_ok} = 2'b01;
        token(7'h05, 4'h4, 6'h02);
        rd(OFS_LAST_EP, 32'h12);
        rd(OFS_EVENT_FLAGS, 32'h48);
        pulse(4'h8);
        rd(OFS_EVENT_FLAGS, 32'h08);
        pulse(4'h4);
        rd(OFS_EVENT_FLAGS, 32'h0c);
        pid_value = 4'ha;
        sof_frame = 11'h5a3;
        pulse(4'h3);
        rd(OFS_LAST_PID, 32'ha);
        rd(OFS_FRAME_CNT, 32'h5a3);
        // soft reset clears captures, keeps configuration
        wr(OFS_IF_RESET, 32'h0);
        rd(OFS_LAST_PID, 32'h0);
        rd(OFS_LAST_EP, 32'h0);
        rd(OFS_FRAME_CNT, 32'h0);
        check("address kept", {25'h0, device_address}, 32'h5);
        tally_and_finish();
    end
endmodule

bind usbli_status usbli_status_chk u_chk (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .tok_valid, .tok_crc5_ok, .tok_pid_ok, .tok_addr,
    .tok_endp, .pkt_accept, .rx_endpoint, .rx_endpoint_valid, .device_address,
    .if_soft_reset, .transmit_enable_low, .force_se0_transmit, .serial_transmit_bit,
    .full_low_speed_serial_select, .power_signal_value, .power_signal_valid);
